// File: verilog/bfdl_consts.vh
/*
  constants for the bus fault detection and lockstep block: line widths,
  the access timer limit, error type codes and the failed-access reply code.
  assumes nothing; definitions only.
*/
`ifndef BFDL_CONSTS_VH
`define BFDL_CONSTS_VH

// address/data and cycle-descriptor widths
`define BFDL_AD_W 32
`define BFDL_CD_W 6
// bus idle cycles tolerated before a timeout
`define BFDL_TIMEOUT_CYC 7'd64
// timer width
`define BFDL_TMR_W 7
// error type codes
`define BFDL_ERR_NONE 3'h0
`define BFDL_ERR_PARITY 3'h1
`define BFDL_ERR_TIMEOUT 3'h2
`define BFDL_ERR_UNSAFE 3'h3
`define BFDL_ERR_ARB 3'h4
`define BFDL_ERR_COMP 3'h5
// failed-access reply code for the cycle-descriptor field, arbitrary
`define BFDL_CD_BAD_ACCESS 6'h3f

`endif

// File: verilog/bfdl_parity.v
/*
  interlaced even parity generator over address/data and cycle-descriptor lines.
  purely combinational; caller registers the result where needed.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bfdl_consts.vh"

module bfdl_parity (
  input wire [`BFDL_AD_W-1:0] ad,
  input wire [`BFDL_CD_W-1:0] cd,
  output reg [1:0] par
);
  integer i;

  // bit 0 covers even lines, bit 1 odd, so adjacent shorts are caught
  always @* begin
    par = 2'h0;
    for (i = 0; i < `BFDL_AD_W; i = i + 1) begin
      par[i % 2] = par[i % 2] ^ ad[i];
    end
    for (i = 0; i < `BFDL_CD_W; i = i + 1) begin
      par[i % 2] = par[i % 2] ^ cd[i];
    end
  end
endmodule // bfdl_parity

`default_nettype wire

// File: verilog/bfdl_top.v
/*
  error detection for a system bus interface unit: parity check and
  generation, outstanding-request timer with failed-access reply, and
  lockstep comparison with a twin unit over request and drive indicators.
  assumes all bus pins arrive from outside the clock domain and are
  synchronised here; the twin runs on the same bus clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bfdl_consts.vh"

// Function
// - two interlaced even check bits generated
// - check bits valid and checked every cycle
// - parity mismatch flagged half cycle later
// - duplicated contention mismatches show on drive_indicator
// - timer runs while own request outstanding
// - reply or deferral clears the timer
// - timeout after more than 64 idle cycles
// - timeout sends failed-access reply packet
// - slow server asserts reply deferral
// - timeout always active, no disable
// - checker compares own output to bus
// - lockstep checks local receipt and bus transmit
// - twin request indicator marks local request
// - sensed request indicator alone: unsafe error
// - master or checker detects request mismatch
// - arbitrate after clean request; master drives
// - both assert drive indicator; checker drives only in alternate drive or when separated
// - sensed drive indicator alone: arbitration error
// - bitwise xor compare of ad and descriptor
// - master self-check raises component error
// - no compare on reports, parity, contention, deferral
// - alternate drive swaps roles every cycle
// - lockstep checks off when disabled or separated
module bfdl_top (
  input wire sys_clk,
  input wire rst_n,
  input wire [`BFDL_AD_W-1:0] bus_ad_in,
  input wire [`BFDL_CD_W-1:0] bus_cd_in,
  input wire [1:0] bus_par_in,
  input wire bus_busy_in,
  output reg [`BFDL_AD_W-1:0] bus_ad_out,
  output reg [`BFDL_CD_W-1:0] bus_cd_out,
  output reg [1:0] bus_par_out,
  output reg bus_oe,
  input wire loc_req,
  input wire [`BFDL_AD_W-1:0] loc_ad,
  input wire [`BFDL_CD_W-1:0] loc_cd,
  input wire arb_won,
  input wire req_at_head,
  input wire reply_rcvd,
  input wire reply_deferral_rcvd,
  input wire slow_access,
  output reg reply_deferral_out,
  output reg arb_req,
  input wire twin_req_in,
  output reg twin_req_out,
  output reg twin_req_oe,
  input wire drive_in,
  output reg drive_out,
  output reg drive_oe,
  input wire is_master,
  input wire alt_drive,
  input wire err_rpt_en,
  input wire separated,
  output reg err_valid,
  output reg [2:0] err_type,
  output reg pair_lost
);
  // two-stage synchronisers for every pin input
  reg [`BFDL_AD_W-1:0] ad_s1_reg, ad_reg;
  reg [`BFDL_CD_W-1:0] cd_s1_reg, cd_reg;
  reg [1:0] par_s1_reg, par_reg;
  reg busy_s1_reg, busy_reg;
  reg treq_s1_reg, treq_reg;
  reg drv_s1_reg, drv_reg;
  // access timer and outstanding flag
  reg [`BFDL_TMR_W-1:0] tmr_reg;
  reg outst_reg;
  // role toggle for alternate drive
  reg turn_reg;
  // what this unit sent two cycles earlier, for the compare
  reg [`BFDL_AD_W-1:0] sent_ad_reg;
  reg [`BFDL_CD_W-1:0] sent_cd_reg;
  reg sent_v_reg;
  // two more stages so the sent copy meets the synchronised bus word
  reg [`BFDL_AD_W-1:0] sent_ad_p1_reg, sent_ad_p2_reg;
  reg [`BFDL_CD_W-1:0] sent_cd_p1_reg, sent_cd_p2_reg;
  reg sent_v_p1_reg, sent_v_p2_reg;
  // own indicators delayed like the sensed ones, else a falling edge looks like a fault
  reg treq_own_d1_reg, treq_own_d2_reg, drv_own_d1_reg, drv_own_d2_reg;
  // parity error waits half a cycle on the falling edge
  reg par_err_neg_reg;
  reg par_err_reg;
  // local request captured for the bus phase
  reg pend_reg;
  reg [`BFDL_AD_W-1:0] pend_ad_reg;
  reg [`BFDL_CD_W-1:0] pend_cd_reg;
  reg timeout_pend_reg;

  wire [1:0] rx_par;
  wire [1:0] tx_par;
  reg [`BFDL_AD_W-1:0] tx_ad;
  reg [`BFDL_CD_W-1:0] tx_cd;
  wire chk_en;
  wire drive_now;
  wire unsafe_err;
  wire arb_err;
  wire comp_err;
  wire timeout;

  // parity of what was received
  bfdl_parity u_rx_par (
    .ad(ad_reg),
    .cd(cd_reg),
    .par(rx_par)
  );

  // parity of what is about to be driven
  bfdl_parity u_tx_par (
    .ad(tx_ad),
    .cd(tx_cd),
    .par(tx_par)
  );

  // synchronise pins: first stage feeds only the second
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ad_s1_reg <= {`BFDL_AD_W{1'b0}};
      ad_reg <= {`BFDL_AD_W{1'b0}};
      cd_s1_reg <= {`BFDL_CD_W{1'b0}};
      cd_reg <= {`BFDL_CD_W{1'b0}};
      par_s1_reg <= 2'h0;
      par_reg <= 2'h0;
      busy_s1_reg <= 1'b0;
      busy_reg <= 1'b0;
      treq_s1_reg <= 1'b0;
      treq_reg <= 1'b0;
      drv_s1_reg <= 1'b0;
      drv_reg <= 1'b0;
    end else begin
      ad_s1_reg <= bus_ad_in;
      ad_reg <= ad_s1_reg;
      cd_s1_reg <= bus_cd_in;
      cd_reg <= cd_s1_reg;
      par_s1_reg <= bus_par_in;
      par_reg <= par_s1_reg;
      busy_s1_reg <= bus_busy_in;
      busy_reg <= busy_s1_reg;
      treq_s1_reg <= twin_req_in;
      treq_reg <= treq_s1_reg;
      drv_s1_reg <= drive_in;
      drv_reg <= drv_s1_reg;
    end
  end

  // checks off when disabled or split
  assign chk_en = err_rpt_en & ~separated;

  // alternate drive flips roles each cycle
  assign drive_now = alt_drive ? (is_master ^ turn_reg) : is_master;

  // output data: timeout reply wins over the pending request
  always @* begin
    if (timeout_pend_reg) begin
      tx_ad = pend_ad_reg;
      tx_cd = `BFDL_CD_BAD_ACCESS;
    end else begin
      tx_ad = pend_ad_reg;
      tx_cd = pend_cd_reg;
    end
  end

  // check bits compared on every cycle, idle included
  always @(negedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      par_err_neg_reg <= 1'b0;
    end else begin
      // mismatch raised half a cycle after receipt
      par_err_neg_reg <= (rx_par != par_reg);
    end
  end

  // bring the half-cycle flag back onto the rising edge
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      par_err_reg <= 1'b0;
    end else begin
      par_err_reg <= par_err_neg_reg;
    end
  end

  // sensed request without own is unsafe
  assign unsafe_err = chk_en & treq_reg & ~treq_own_d2_reg;
  // sensed drive without own is arbitration error
  // duplicated contention faults appear here too
  assign arb_err = chk_en & drv_reg & ~drv_own_d2_reg;
  // xor compare of ad and descriptor only
  // checker compares own intent with bus
  // master self-check uses the same compare
  // covers transmit of locally received data
  assign comp_err = chk_en & sent_v_reg &
                    (|(ad_reg ^ sent_ad_reg) | |(cd_reg ^ sent_cd_reg));

  // timeout after more than 64 idle cycles
  assign timeout = outst_reg & (tmr_reg == `BFDL_TIMEOUT_CYC) & ~busy_reg;

  // access timer; no enable input exists
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_reg <= {`BFDL_TMR_W{1'b0}};
      outst_reg <= 1'b0;
    end else if (reply_rcvd | reply_deferral_rcvd | timeout) begin
      tmr_reg <= {`BFDL_TMR_W{1'b0}};
      outst_reg <= 1'b0;
    end else if (req_at_head & ~outst_reg) begin
      // start when own request at head
      tmr_reg <= {`BFDL_TMR_W{1'b0}};
      outst_reg <= 1'b1;
    end else if (outst_reg) begin
      // only idle cycles count toward the limit
      if (busy_reg) begin
        tmr_reg <= {`BFDL_TMR_W{1'b0}};
      end else if (tmr_reg != `BFDL_TIMEOUT_CYC) begin
        tmr_reg <= tmr_reg + 7'd1;
      end
    end
  end

  // local request capture and twin indicator
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 1'b0;
      pend_ad_reg <= {`BFDL_AD_W{1'b0}};
      pend_cd_reg <= {`BFDL_CD_W{1'b0}};
      twin_req_out <= 1'b0;
      timeout_pend_reg <= 1'b0;
    end else begin
      if (loc_req & ~pend_reg) begin
        // tell the twin a request arrived
        pend_reg <= 1'b1;
        pend_ad_reg <= loc_ad;
        pend_cd_reg <= loc_cd;
        twin_req_out <= 1'b1;
      end else if (arb_won & pend_reg) begin
        pend_reg <= 1'b0;
        twin_req_out <= 1'b0;
      end
      // timeout reply queued until the bus is won
      if (timeout) begin
        timeout_pend_reg <= 1'b1;
      end else if (arb_won & timeout_pend_reg) begin
        timeout_pend_reg <= 1'b0;
      end
    end
  end

  // arbitrate while a request is pending unless an unsafe error is flagged
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arb_req <= 1'b0;
    end else begin
      arb_req <= (pend_reg | timeout_pend_reg) & ~arb_won & ~unsafe_err;
    end
  end

  // bus drive, drive indicator and sent copy for compare
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      turn_reg <= 1'b0;
      bus_ad_out <= {`BFDL_AD_W{1'b0}};
      bus_cd_out <= {`BFDL_CD_W{1'b0}};
      bus_par_out <= 2'h0;
      bus_oe <= 1'b0;
      drive_out <= 1'b0;
      drive_oe <= 1'b0;
      sent_ad_reg <= {`BFDL_AD_W{1'b0}};
      sent_cd_reg <= {`BFDL_CD_W{1'b0}};
      sent_v_reg <= 1'b0;
      sent_ad_p1_reg <= {`BFDL_AD_W{1'b0}};
      sent_ad_p2_reg <= {`BFDL_AD_W{1'b0}};
      sent_cd_p1_reg <= {`BFDL_CD_W{1'b0}};
      sent_cd_p2_reg <= {`BFDL_CD_W{1'b0}};
      sent_v_p1_reg <= 1'b0;
      sent_v_p2_reg <= 1'b0;
      treq_own_d1_reg <= 1'b0;
      treq_own_d2_reg <= 1'b0;
      drv_own_d1_reg <= 1'b0;
      drv_own_d2_reg <= 1'b0;
    end else begin
      turn_reg <= ~turn_reg;
      bus_ad_out <= tx_ad;
      bus_cd_out <= tx_cd;
      bus_par_out <= tx_par;
      // both indicate drive; drive_now unit enables buffers, both units when separated
      drive_out <= arb_won;
      drive_oe <= arb_won;
      bus_oe <= arb_won & (drive_now | separated);
      // sent copy trails the bus by the two synchroniser stages
      sent_ad_p1_reg <= tx_ad;
      sent_ad_p2_reg <= sent_ad_p1_reg;
      sent_ad_reg <= sent_ad_p2_reg;
      sent_cd_p1_reg <= tx_cd;
      sent_cd_p2_reg <= sent_cd_p1_reg;
      sent_cd_reg <= sent_cd_p2_reg;
      sent_v_p1_reg <= arb_won;
      sent_v_p2_reg <= sent_v_p1_reg;
      sent_v_reg <= sent_v_p2_reg;
      treq_own_d1_reg <= twin_req_out;
      treq_own_d2_reg <= treq_own_d1_reg;
      drv_own_d1_reg <= drive_out;
      drv_own_d2_reg <= drv_own_d1_reg;
    end
  end

  // twin request pin enable follows own request
  always @* begin
    twin_req_oe = twin_req_out;
  end

  // deferral for accesses longer than the timer
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reply_deferral_out <= 1'b0;
    end else begin
      reply_deferral_out <= slow_access;
    end
  end

  // one-cycle typed error event, fixed priority
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_valid <= 1'b0;
      err_type <= `BFDL_ERR_NONE;
      pair_lost <= 1'b0;
    end else begin
      err_valid <= par_err_reg | timeout | unsafe_err | arb_err | comp_err;
      if (unsafe_err) begin
        err_type <= `BFDL_ERR_UNSAFE;
      end else if (arb_err) begin
        err_type <= `BFDL_ERR_ARB;
      end else if (comp_err) begin
        err_type <= `BFDL_ERR_COMP;
      end else if (par_err_reg) begin
        err_type <= `BFDL_ERR_PARITY;
      end else if (timeout) begin
        err_type <= `BFDL_ERR_TIMEOUT;
      end else begin
        err_type <= `BFDL_ERR_NONE;
      end
      // loss of pair sync is permanent until reset
      if (unsafe_err) begin
        pair_lost <= 1'b1;
      end
    end
  end
endmodule // bfdl_top

`default_nettype wire

// File: verif/bfdl_props.sv
/* port checker for bfdl_top, bound to every instance.
   assumes levels and pins change away from the rising edge. */
`timescale 1ns/1ps
`default_nettype none
`include "bfdl_consts.vh"
module bfdl_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [`BFDL_AD_W-1:0] bus_ad_out,
  input wire logic [`BFDL_CD_W-1:0] bus_cd_out,
  input wire logic [1:0] bus_par_out,
  input wire logic bus_oe,
  input wire logic loc_req,
  input wire logic arb_won,
  input wire logic slow_access,
  input wire logic reply_deferral_out,
  input wire logic twin_req_out,
  input wire logic drive_out,
  input wire logic is_master,
  input wire logic alt_drive,
  input wire logic err_rpt_en,
  input wire logic separated,
  input wire logic err_valid,
  input wire logic [2:0] err_type,
  input wire logic pair_lost
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_pulse; err_valid |=> !err_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("error event too long");
  property p_type; err_valid |-> err_type != 0 && err_type <= 3'h5; endproperty
  a_type: assert property (p_type) else $error("bad error type");
  property p_sticky; pair_lost |=> pair_lost; endproperty
  a_sticky: assert property (p_sticky) else $error("pair_lost dropped");
  property p_lost; err_valid && err_type == 3'h3 |-> ##[0:1] pair_lost; endproperty
  a_lost: assert property (p_lost) else $error("unsafe error without pair_lost");
  property p_defer; reply_deferral_out == $past(slow_access); endproperty
  a_defer: assert property (p_defer) else $error("deferral not following");
  property p_drive; drive_out == $past(arb_won); endproperty
  a_drive: assert property (p_drive) else $error("drive indicator wrong");
  property p_par;
    bus_par_out == {(^(bus_ad_out & 32'haaaaaaaa)) ^ (^(bus_cd_out & 6'h2a)),
                    (^(bus_ad_out & 32'h55555555)) ^ (^(bus_cd_out & 6'h15))};
  endproperty
  a_par: assert property (p_par) else $error("check bits wrong");
  property p_quiet; (!is_master && !alt_drive && !separated) [*2] |-> !bus_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("checker drives bus");
  property p_mask; err_valid && err_type >= 3'h3 |-> err_rpt_en && !separated; endproperty
  a_mask: assert property (p_mask) else $error("lockstep error while off");
  property p_treq; $rose(twin_req_out) |-> $past(loc_req); endproperty
  a_treq: assert property (p_treq) else $error("request indicator uncaused");
  property p_oe; $rose(bus_oe) |-> $past(arb_won); endproperty
  a_oe: assert property (p_oe) else $error("drive before winning");
  c_par: cover property (err_valid && err_type == 3'h1);
  c_lost: cover property ($rose(pair_lost));
  c_oe: cover property ($rose(bus_oe));
endmodule // bfdl_props
bind bfdl_top bfdl_props u_bfdl_props (.sys_clk, .rst_n, .bus_ad_out, .bus_cd_out,
  .bus_par_out, .bus_oe, .loc_req, .arb_won, .slow_access, .reply_deferral_out,
  .twin_req_out, .drive_out, .is_master, .alt_drive, .err_rpt_en, .separated,
  .err_valid, .err_type, .pair_lost);
`default_nettype wire

// File: verif/bfdl_far_model.sv
/* far side: other bus agents and the lockstep twin.
   assumes the twin mirrors our indicators unless told to act alone. */
`timescale 1ns/1ps
`default_nettype none
module bfdl_far_model (
  input wire logic sys_clk,
  input wire logic [31:0] bus_ad_out,
  input wire logic [5:0] bus_cd_out,
  input wire logic bus_oe,
  input wire logic twin_req_out,
  input wire logic drive_out,
  input wire logic bad_par,
  input wire logic twin_alone,
  input wire logic drive_alone,
  input wire logic bad_ad,
  output logic [31:0] bus_ad_in,
  output logic [5:0] bus_cd_in,
  output logic [1:0] bus_par_in,
  output logic twin_req_in,
  output logic drive_in
);
  // idle pattern moves every cycle so a stale word never matches
  logic [31:0] idle_reg = 32'h0;
  always @(posedge sys_clk) idle_reg <= idle_reg + 32'h01010101;
  // interlaced even parity, valid on idle cycles as well
  always @* begin
    // a driving twin shows the same word; bad_ad corrupts one line of it
    bus_ad_in = (bus_oe | drive_out) ? bus_ad_out ^ {31'h0, bad_ad} : idle_reg;
    bus_cd_in = (bus_oe | drive_out) ? bus_cd_out : idle_reg[5:0];
    bus_par_in[0] = (^(bus_ad_in & 32'h55555555)) ^ (^(bus_cd_in & 6'h15));
    bus_par_in[1] = (^(bus_ad_in & 32'haaaaaaaa)) ^ (^(bus_cd_in & 6'h2a)) ^ bad_par;
  end
  // twin mirrors indicators, or raises one alone
  assign twin_req_in = twin_req_out | twin_alone;
  assign drive_in = drive_out | drive_alone;
endmodule // bfdl_far_model
`default_nettype wire

// File: verif/bus_fault_detection_lockstep_tb_top.sv
/* bench for bfdl_top with the far side model; prints mismatches and verdict.
   assumes one 100 MHz clock; inputs move on the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module bus_fault_detection_lockstep_tb_top;
  logic sys_clk, rst_n, bus_busy_in, loc_req, arb_won, req_at_head, reply_rcvd;
  logic reply_deferral_rcvd, slow_access, is_master, alt_drive, err_rpt_en, separated;
  logic bad_par, twin_alone, drive_alone, bus_oe, reply_deferral_out, arb_req;
  logic twin_req_in, twin_req_out, twin_req_oe, drive_in, drive_out, drive_oe;
  logic err_valid, pair_lost, bad_ad;
  logic [31:0] loc_ad, bus_ad_in, bus_ad_out;
  logic [5:0] loc_cd, bus_cd_in, bus_cd_out;
  logic [1:0] bus_par_in, bus_par_out;
  logic [2:0] err_type;
  int fail_count = 0, cmp_count = 0, n;
  bfdl_top u_bfdl_top (.sys_clk, .rst_n, .bus_ad_in, .bus_cd_in, .bus_par_in,
    .bus_busy_in, .bus_ad_out, .bus_cd_out, .bus_par_out, .bus_oe, .loc_req, .loc_ad,
    .loc_cd, .arb_won, .req_at_head, .reply_rcvd, .reply_deferral_rcvd, .slow_access,
    .reply_deferral_out, .arb_req, .twin_req_in, .twin_req_out, .twin_req_oe,
    .drive_in, .drive_out, .drive_oe, .is_master, .alt_drive, .err_rpt_en,
    .separated, .err_valid, .err_type, .pair_lost);
  bfdl_far_model u_bfdl_far_model (.sys_clk, .bus_ad_out, .bus_cd_out, .bus_oe,
    .twin_req_out, .drive_out, .bad_par, .twin_alone, .drive_alone, .bad_ad, .bus_ad_in,
    .bus_cd_in, .bus_par_in, .twin_req_in, .drive_in);
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  task close_out;
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // waits a bounded time for an error event, then judges its type
  task wait_err(input logic [2:0] t, input int hi);
    n = 0;
    while (err_valid !== 1'b1 && n < hi) begin
      @(negedge sys_clk);
      n++;
    end
    chk("err_valid", 1, err_valid);
    chk("err_type", t, err_type);
  endtask
  // counts error events over a quiet stretch
  task no_err(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(negedge sys_clk);
      n += (err_valid !== 1'b0);
    end
    chk("no_err", 0, n);
  endtask
  task t_parity;
    bad_par = 1;
    @(negedge sys_clk) bad_par = 0;
    wait_err(3'h1, 8);
  endtask
  task t_arb;
    drive_alone = 1;
    @(negedge sys_clk) drive_alone = 0;
    wait_err(3'h4, 8);
    for (int i = 0; i < 2; i++) begin
      @(negedge sys_clk);
      err_rpt_en = i;
      separated = i;
      @(negedge sys_clk) drive_alone = 1;
      @(negedge sys_clk) drive_alone = 0;
      no_err(10);
    end
    separated = 0;
  endtask
  task t_timeout;
    err_rpt_en = 0;
    separated = 1;
    req_at_head = 1;
    wait_err(3'h2, 90);
    chk("late", 1, n > 64);
    arb_won = 1;
    @(negedge sys_clk) arb_won = 0;
    chk("rpl_cd", 6'h3f, bus_cd_out);
    chk("rpl_oe", 1, bus_oe);
    req_at_head = 0;
    for (int i = 0; i < 2; i++) begin
      @(negedge sys_clk) req_at_head = 1;
      repeat (40) @(negedge sys_clk);
      {reply_rcvd, reply_deferral_rcvd} = i ? 2'b10 : 2'b01;
      @(negedge sys_clk) {reply_rcvd, reply_deferral_rcvd, req_at_head} = 3'b000;
      no_err(70);
    end
    err_rpt_en = 1;
    separated = 0;
  endtask
  task t_req;
    for (int i = 0; i < 3; i++) begin
      is_master = (i != 0);
      bad_ad = (i == 2);
      loc_ad = 32'ha5a50f0f ^ i;
      loc_cd = 6'h2a;
      repeat (3) @(negedge sys_clk);
      loc_req = 1;
      @(negedge sys_clk) loc_req = 0;
      chk("twin_req", 1, twin_req_out);
      chk("twin_req_oe", 1, twin_req_oe);
      n = 0;
      while (arb_req !== 1'b1 && n < 4) @(negedge sys_clk) n++;
      chk("arb_req", 1, arb_req);
      arb_won = 1;
      @(negedge sys_clk) chk("drive", 1, drive_out);
      chk("drive_oe", 1, drive_oe);
      chk("oe", i != 0, bus_oe);
      if (i) chk("ad", loc_ad, bus_ad_out);
      if (i) chk("cd", loc_cd, bus_cd_out);
      arb_won = 0;
      if (i == 2) wait_err(3'h5, 8);
      else no_err(8);
      bad_ad = 0;
    end
  endtask
  // alternate drive: over two won cycles the buffers open exactly once
  task t_alt;
    alt_drive = 1;
    loc_req = 1;
    @(negedge sys_clk) loc_req = 0;
    arb_won = 1;
    n = 0;
    repeat (2) @(negedge sys_clk) n += bus_oe;
    arb_won = 0;
    chk("alt_oe", 1, n);
    no_err(8);
    alt_drive = 0;
  endtask
  task t_unsafe;
    slow_access = 1;
    @(negedge sys_clk) chk("defer", 1, reply_deferral_out);
    slow_access = 0;
    twin_alone = 1;
    @(negedge sys_clk) twin_alone = 0;
    wait_err(3'h3, 8);
    repeat (2) @(negedge sys_clk);
    chk("pair_lost", 1, pair_lost);
  endtask
  initial begin
    {rst_n, bus_busy_in, loc_req, arb_won, req_at_head, reply_rcvd} = 0;
    {reply_deferral_rcvd, slow_access, alt_drive, separated, bad_par} = 0;
    {twin_alone, drive_alone, bad_ad, loc_ad, loc_cd} = 0;
    {is_master, err_rpt_en} = 2'b11;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk) rst_n = 1;
    repeat (6) @(negedge sys_clk);
    t_parity;
    t_arb;
    t_timeout;
    t_req;
    t_alt;
    t_unsafe;
    close_out;
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    close_out;
  end
endmodule // bus_fault_detection_lockstep_tb_top
`default_nettype wire
